// *** rad_pkg.sv ***
// package for the operand address decoder: field positions, opcode
// groups and mode codes. assumes a single core clock domain.
package rad_pkg;
	localparam int RAD_IW = 16; // instruction width
	localparam int RAD_DW = 32; // register / address width
	localparam int RAD_N_HI = 11;
	localparam int RAD_N_LO = 8;
	localparam int RAD_M_HI = 7;
	localparam int RAD_M_LO = 4;
	localparam logic [31:0] RAD_LONG_MASK = 32'hFFFFFFFC;
	localparam logic [31:0] RAD_ZERO = 32'h00000000;
	localparam logic [1:0] RAD_SZ_B = 2'h0;
	localparam logic [1:0] RAD_SZ_W = 2'h1;
	localparam logic [1:0] RAD_SZ_L = 2'h2;
	// addressing mode selected by the pipeline
	typedef enum logic [3:0] {
		RAD_M_IND = 4'h0, // @Rn
		RAD_M_POST = 4'h1, // @Rn+
		RAD_M_PRE = 4'h2, // @-Rn
		RAD_M_DISP4 = 4'h3, // @(disp4,Rm)
		RAD_M_GBASE = 4'h4, // @(disp8,global base)
		RAD_M_PCD = 4'h5, // @(disp8,PC)
		RAD_M_BR8 = 4'h6, // short branch
		RAD_M_BR12 = 4'h7, // long branch
		RAD_M_BRREG = 4'h8, // PC + Rn
		RAD_M_IDX = 4'h9, // @(R0,Rn)
		RAD_M_NONE = 4'hF
	} rad_mode_e;
	// immediate flavours
	typedef enum logic [1:0] {
		RAD_I_ZX = 2'h0, // test/and/or/xor
		RAD_I_SX = 2'h1, // move/add/compare-equal
		RAD_I_TRAP = 2'h2, // software trap vector
		RAD_I_NONE = 2'h3
	} rad_imm_e;
	// branch kinds
	typedef enum logic [2:0] {
		RAD_B_NONE = 3'h0,
		RAD_B_UNC = 3'h1, // always delayed
		RAD_B_CT = 3'h2, // taken on flag set
		RAD_B_CF = 3'h3, // taken on flag clear
		RAD_B_CTS = 3'h4, // delayed, flag set
		RAD_B_CFS = 3'h5 // delayed, flag clear
	} rad_br_e;
endpackage : rad_pkg

// *** rad_decoder.sv ***
// operand address decoder: fields, immediates, effective addresses,
// branch targets and delay-slot flags for 16-bit instructions.
// assumes the pipeline supplies register contents and mode selection
// and that the flag input is the current condition bit.
// **********************************************************
// decoder top
// **********************************************************
module rad_decoder #(
	parameter int DW = 32
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// instruction request from fetch
	input wire logic INSN_VALID,
	input wire logic [rad_pkg::RAD_IW-1:0] INSN_WORD,
	input wire rad_pkg::rad_mode_e ADDR_MODE,
	input wire rad_pkg::rad_imm_e IMM_KIND,
	input wire rad_pkg::rad_br_e BRANCH_KIND,
	input wire logic [1:0] OP_SIZE,
	input wire logic MULTIPLY_ACCUMULATE_OP,
	input wire logic LOGIC_MEM_OP,
	// operands from register file
	input wire logic [DW-1:0] PC_VALUE,
	input wire logic [DW-1:0] RN_VALUE,
	input wire logic [DW-1:0] RM_VALUE,
	input wire logic [DW-1:0] R0_VALUE,
	input wire logic [DW-1:0] GLOBAL_BASE_POINTER,
	input wire logic COND_FLAG,
	// load data return
	input wire logic LOAD_VALID,
	input wire logic [1:0] LOAD_SIZE,
	input wire logic [DW-1:0] LOAD_RAW,
	// decoded fields
	output logic OUT_VALID,
	output logic [3:0] DEST_REG,
	output logic [3:0] SRC_REG,
	output logic [DW-1:0] IMM_VALUE,
	output logic [DW-1:0] EFF_ADDR,
	output logic WB_EN,
	output logic [3:0] WB_REG,
	output logic [DW-1:0] WB_VALUE,
	output logic SRC2_POST_INC,
	output logic RMW_EN,
	output logic ADDR_ERR,
	// branch control
	output logic BR_TAKE,
	output logic [DW-1:0] BR_TARGET,
	output logic BR_DELAY_SLOT,
	// load result
	output logic LOAD_OUT_VALID,
	output logic [DW-1:0] LOAD_EXT
);
	import rad_pkg::*;

	// **********************************************************
	// helpers
	// **********************************************************
	// operand size step 1/2/4, shared by the increment and decrement paths
	function automatic logic [DW-1:0] size_step(input logic [1:0] sz);
		logic [DW-1:0] s;
		s = DW'(1);
		if (sz == RAD_SZ_W) begin
			s = DW'(2);
		end else if (sz == RAD_SZ_L) begin
			s = DW'(4);
		end
		return s;
	endfunction : size_step

	// displacement scaled by the operand size
	function automatic logic [DW-1:0] scale(input logic [DW-1:0] d,
		input logic [1:0] sz);
		logic [DW-1:0] r;
		r = d;
		if (sz == RAD_SZ_W) begin
			r = d << 1;
		end else if (sz == RAD_SZ_L) begin
			r = d << 2;
		end
		return r;
	endfunction : scale

	// **********************************************************
	// field extraction
	// **********************************************************
	logic [3:0] fld_n;
	logic [3:0] fld_m;
	logic [3:0] fld_d4;
	logic [7:0] fld_d8;
	logic [11:0] fld_d12;
	// nibble positions fixed by the 16-bit format
	assign fld_n = INSN_WORD[RAD_N_HI:RAD_N_LO];
	assign fld_m = INSN_WORD[RAD_M_HI:RAD_M_LO];
	assign fld_d4 = INSN_WORD[3:0];
	assign fld_d8 = INSN_WORD[7:0];
	assign fld_d12 = INSN_WORD[11:0];

	// **********************************************************
	// immediates
	// **********************************************************
	logic [DW-1:0] nxt_imm;
	always_comb begin
		case (IMM_KIND)
			RAD_I_ZX: nxt_imm = DW'(fld_d8);
			RAD_I_SX: nxt_imm = {{(DW-8){fld_d8[7]}}, fld_d8};
			RAD_I_TRAP: nxt_imm = DW'({fld_d8, 2'h0});
			default: nxt_imm = RAD_ZERO;
		endcase
	end

	// **********************************************************
	// effective address and register write-back
	// **********************************************************
	logic [DW-1:0] nxt_ea;
	logic nxt_wb;
	logic [DW-1:0] nxt_wbv;
	logic [DW-1:0] dec_val;
	logic [DW-1:0] pc_base;
	assign dec_val = RN_VALUE - size_step(OP_SIZE);
	// longword literal tables sit on 4-byte lines, so PC low bits drop
	assign pc_base = (OP_SIZE == RAD_SZ_L) ? (PC_VALUE & RAD_LONG_MASK)
		: PC_VALUE;
	always_comb begin
		nxt_ea = RAD_ZERO;
		nxt_wb = 1'b0;
		nxt_wbv = RAD_ZERO;
		case (ADDR_MODE)
			RAD_M_IND: nxt_ea = RN_VALUE;
			RAD_M_POST: begin
				nxt_ea = RN_VALUE;
				nxt_wb = 1'b1;
				nxt_wbv = RN_VALUE + size_step(OP_SIZE);
			end
			RAD_M_PRE: begin
				nxt_ea = dec_val;
				nxt_wb = 1'b1;
				nxt_wbv = dec_val;
			end
			RAD_M_DISP4: nxt_ea = RM_VALUE + scale(DW'(fld_d4), OP_SIZE);
			RAD_M_GBASE: nxt_ea = GLOBAL_BASE_POINTER
				+ scale(DW'(fld_d8), OP_SIZE);
			RAD_M_PCD: nxt_ea = pc_base + scale(DW'(fld_d8), OP_SIZE);
			RAD_M_IDX: nxt_ea = R0_VALUE + RN_VALUE;
			default: nxt_ea = RAD_ZERO;
		endcase
	end

	// misaligned halfword/longword access; bytes go anywhere
	logic nxt_aerr;
	logic mem_mode;
	assign mem_mode = (ADDR_MODE == RAD_M_IND) || (ADDR_MODE == RAD_M_POST)
		|| (ADDR_MODE == RAD_M_PRE) || (ADDR_MODE == RAD_M_DISP4)
		|| (ADDR_MODE == RAD_M_GBASE) || (ADDR_MODE == RAD_M_PCD)
		|| (ADDR_MODE == RAD_M_IDX);
	assign nxt_aerr = mem_mode && (((OP_SIZE == RAD_SZ_W) && nxt_ea[0])
		|| ((OP_SIZE == RAD_SZ_L) && (nxt_ea[1:0] != 2'h0)));

	// **********************************************************
	// branches
	// **********************************************************
	logic [DW-1:0] nxt_tgt;
	logic nxt_take;
	logic nxt_slot;
	always_comb begin
		case (ADDR_MODE)
			RAD_M_BR8: nxt_tgt = PC_VALUE
				+ {{(DW-9){fld_d8[7]}}, fld_d8, 1'b0};
			RAD_M_BR12: nxt_tgt = PC_VALUE
				+ {{(DW-13){fld_d12[11]}}, fld_d12, 1'b0};
			RAD_M_BRREG: nxt_tgt = PC_VALUE + RN_VALUE;
			default: nxt_tgt = PC_VALUE;
		endcase
	end
	// flag is only read here; this block never writes it
	always_comb begin
		case (BRANCH_KIND)
			RAD_B_UNC: begin
				nxt_take = 1'b1;
				nxt_slot = 1'b1;
			end
			RAD_B_CT: begin
				nxt_take = COND_FLAG;
				nxt_slot = 1'b0;
			end
			RAD_B_CF: begin
				nxt_take = !COND_FLAG;
				nxt_slot = 1'b0;
			end
			RAD_B_CTS: begin
				nxt_take = COND_FLAG;
				nxt_slot = 1'b1;
			end
			RAD_B_CFS: begin
				nxt_take = !COND_FLAG;
				nxt_slot = 1'b1;
			end
			default: begin
				nxt_take = 1'b0;
				nxt_slot = 1'b0;
			end
		endcase
	end

	// **********************************************************
	// registered decode outputs
	// **********************************************************
	// one-cycle latency; all outputs qualified by OUT_VALID
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			OUT_VALID <= 1'b0;
			DEST_REG <= 4'h0;
			SRC_REG <= 4'h0;
			IMM_VALUE <= RAD_ZERO;
			EFF_ADDR <= RAD_ZERO;
			WB_EN <= 1'b0;
			WB_REG <= 4'h0;
			WB_VALUE <= RAD_ZERO;
			SRC2_POST_INC <= 1'b0;
			RMW_EN <= 1'b0;
			ADDR_ERR <= 1'b0;
		end else begin
			OUT_VALID <= INSN_VALID;
			DEST_REG <= fld_n;
			SRC_REG <= fld_m;
			IMM_VALUE <= nxt_imm;
			EFF_ADDR <= nxt_ea;
			WB_EN <= INSN_VALID && nxt_wb;
			WB_REG <= fld_n;
			WB_VALUE <= nxt_wbv;
			// the n field becomes a second pointer, never a destination
			SRC2_POST_INC <= INSN_VALID && MULTIPLY_ACCUMULATE_OP;
			// bit ops on memory go read-modify-write, no register load
			RMW_EN <= INSN_VALID && LOGIC_MEM_OP && mem_mode;
			ADDR_ERR <= INSN_VALID && nxt_aerr;
		end
	end

	// branch outputs kept apart from operand decode
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			BR_TAKE <= 1'b0;
			BR_TARGET <= RAD_ZERO;
			BR_DELAY_SLOT <= 1'b0;
		end else begin
			BR_TAKE <= INSN_VALID && nxt_take;
			BR_TARGET <= nxt_tgt;
			BR_DELAY_SLOT <= INSN_VALID && nxt_take && nxt_slot;
		end
	end

	// **********************************************************
	// load extension
	// **********************************************************
	logic [DW-1:0] nxt_ld;
	always_comb begin
		case (LOAD_SIZE)
			RAD_SZ_B: nxt_ld = {{(DW-8){LOAD_RAW[7]}}, LOAD_RAW[7:0]};
			RAD_SZ_W: nxt_ld = {{(DW-16){LOAD_RAW[15]}}, LOAD_RAW[15:0]};
			default: nxt_ld = LOAD_RAW;
		endcase
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			LOAD_OUT_VALID <= 1'b0;
			LOAD_EXT <= RAD_ZERO;
		end else begin
			LOAD_OUT_VALID <= LOAD_VALID;
			LOAD_EXT <= nxt_ld;
		end
	end

	// **********************************************************
	// checks
	// **********************************************************
	post_inc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(INSN_VALID && ADDR_MODE == RAD_M_POST && OP_SIZE == RAD_SZ_L)
		|=> (WB_EN && WB_VALUE == EFF_ADDR + 32'h4))
		else $error("post increment step wrong");
	pre_dec_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(INSN_VALID && ADDR_MODE == RAD_M_PRE)
		|=> (WB_EN && WB_VALUE == EFF_ADDR))
		else $error("pre decrement address mismatch");
	pc_long_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(INSN_VALID && ADDR_MODE == RAD_M_PCD && OP_SIZE == RAD_SZ_L)
		|=> (EFF_ADDR[1:0] == 2'h0))
		else $error("longword PC-relative address not aligned");
	br_short_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(ADDR_MODE == RAD_M_BR8) |=> (BR_TARGET == $past(PC_VALUE)
		+ {{24{$past(INSN_WORD[7])}}, $past(INSN_WORD[7:0])} * 2))
		else $error("short branch target wrong");
	uncond_slot_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(INSN_VALID && BRANCH_KIND == RAD_B_UNC) |=> (BR_TAKE && BR_DELAY_SLOT))
		else $error("unconditional branch not delayed");
	cond_take_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(INSN_VALID && BRANCH_KIND == RAD_B_CF) |=> (BR_TAKE == !$past(COND_FLAG)))
		else $error("conditional branch ignores flag");
	imm_sign_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(IMM_KIND == RAD_I_SX) |=> (IMM_VALUE[31:7] == {25{IMM_VALUE[7]}}))
		else $error("signed immediate not extended");
	trap_vec_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(IMM_KIND == RAD_I_TRAP) |=> (IMM_VALUE == {22'h0, $past(INSN_WORD[7:0]), 2'h0}))
		else $error("trap vector offset wrong");
	addr_err_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(OUT_VALID && $past(mem_mode) && $past(OP_SIZE) == RAD_SZ_W && EFF_ADDR[0])
		|-> ADDR_ERR)
		else $error("odd halfword address not flagged");
	load_ext_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(LOAD_VALID && LOAD_SIZE == RAD_SZ_B) |=> (LOAD_EXT[31:8] == {24{LOAD_EXT[7]}}))
		else $error("byte load not sign extended");
endmodule : rad_decoder

// *** rad_load_model.sv ***
// load return model for the operand address decoder bench.
// assumes the bench raises req just after a clock edge and drops it just after a later one.
// **********************************************************
// data memory return side
// **********************************************************
module rad_load_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// command from the bench
	input wire logic req,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_data,
	// return toward the decoder
	output logic load_valid,
	output logic [1:0] load_size,
	output logic [31:0] load_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_ff;
	// remember the last word so an idle bus can show its inverse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last_ff <= 32'h00000000;
		end else if (req) begin
			last_ff <= req_data;
		end
	end
	// idle data is never the stale value, so a decoder that ignores
	// the valid strobe cannot match by luck
	always_comb begin
		load_valid = req;
		load_size = req_size;
		load_raw = req ? req_data : ~last_ff;
	end
endmodule : rad_load_model

// *** tb.sv ***
// self-checking bench for the operand address decoder.
// assumes one 100 MHz clock and outputs one cycle after each input edge.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rad_pkg::*;
	logic clk, rst, iv, mulacc, lmem, flag, lreq;
	logic [15:0] iw;
	rad_mode_e mode;
	rad_imm_e ik;
	rad_br_e bk;
	logic [1:0] sz, lsz, lsize;
	logic [31:0] pc, rn, rm, r0, gbp, ldat, lraw;
	logic ov, wbe, s2, rmw, aerr, bt, bds, lov, lv;
	logic [3:0] dr, srcr, wbr;
	logic [31:0] imm, ea, wbv, btg, lext;
	int bad_count, n_tests;
	// **********************************************************
	// instances
	// **********************************************************
	rad_decoder u_rad_decoder (.CORE_CLK(clk), .RST(rst), .INSN_VALID(iv),
		.INSN_WORD(iw), .ADDR_MODE(mode), .IMM_KIND(ik), .BRANCH_KIND(bk),
		.OP_SIZE(sz), .MULTIPLY_ACCUMULATE_OP(mulacc), .LOGIC_MEM_OP(lmem),
		.PC_VALUE(pc), .RN_VALUE(rn), .RM_VALUE(rm), .R0_VALUE(r0),
		.GLOBAL_BASE_POINTER(gbp), .COND_FLAG(flag), .LOAD_VALID(lv),
		.LOAD_SIZE(lsize), .LOAD_RAW(lraw), .OUT_VALID(ov), .DEST_REG(dr),
		.SRC_REG(srcr), .IMM_VALUE(imm), .EFF_ADDR(ea), .WB_EN(wbe),
		.WB_REG(wbr), .WB_VALUE(wbv), .SRC2_POST_INC(s2), .RMW_EN(rmw),
		.ADDR_ERR(aerr), .BR_TAKE(bt), .BR_TARGET(btg),
		.BR_DELAY_SLOT(bds), .LOAD_OUT_VALID(lov), .LOAD_EXT(lext));
	rad_load_model u_rad_load_model (.clk(clk), .rst(rst), .req(lreq),
		.req_size(lsz), .req_data(ldat), .load_valid(lv),
		.load_size(lsize), .load_raw(lraw));
	// **********************************************************
	// helpers
	// **********************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// present one instruction, then let the answering edge land
	task automatic go(input logic v, input rad_mode_e m,
		input logic [15:0] w, input logic [1:0] s);
		iv = v;
		mode = m;
		iw = w;
		sz = s;
		@(posedge clk);
		#1;
	endtask : go
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// **********************************************************
	// scenarios
	// **********************************************************
	task automatic t_ptr();
		for (int i = 0; i < 3; i++) begin
			rn = 32'h00001000;
			go(1'b1, RAD_M_POST, 16'h6A36, 2'(i));
			chk(ea, 32'h00001000);
			chk(wbv, 32'h00001000 + (32'h1 << i));
			chk({ov, wbe, wbr, dr, srcr}, {2'b11, 4'hA, 4'hA, 4'h3});
			go(1'b1, RAD_M_PRE, 16'h2B46, 2'(i));
			chk(ea, 32'h00001000 - (32'h1 << i));
			chk({wbe, wbr}, {1'b1, 4'hB});
			chk(wbv, 32'h00001000 - (32'h1 << i));
		end
	endtask : t_ptr
	task automatic t_disp();
		rm = 32'h00002000;
		gbp = 32'h00003000;
		for (int i = 0; i < 3; i++) begin
			go(1'b1, RAD_M_DISP4, 16'h853F, 2'(i));
			chk(ea, 32'h00002000 + 32'd15 * (32'h1 << i));
			go(1'b1, RAD_M_GBASE, 16'hC0FF, 2'(i));
			chk(ea, 32'h00003000 + 32'd255 * (32'h1 << i));
		end
		pc = 32'h00001002;
		go(1'b1, RAD_M_PCD, 16'h91FF, RAD_SZ_W);
		chk(ea, 32'h00001200);
		go(1'b1, RAD_M_PCD, 16'hD1FF, RAD_SZ_L);
		chk(ea, 32'h000013FC);
	endtask : t_disp
	task automatic t_branch();
		rad_br_e kinds [8] = '{RAD_B_UNC, RAD_B_CT, RAD_B_CT, RAD_B_CF,
			RAD_B_CF, RAD_B_CTS, RAD_B_CFS, RAD_B_NONE};
		logic [7:0] fl = 8'b0011_0010;
		logic [7:0] tk = 8'b0110_1011;
		logic [7:0] sl = 8'b0110_0001;
		pc = 32'h00001000;
		for (int i = 0; i < 8; i++) begin
			bk = kinds[i];
			flag = fl[i];
			go(1'b1, RAD_M_BR8, 16'h8B80, RAD_SZ_B);
			chk(bt, tk[i]);
			chk(bds, sl[i]);
		end
		bk = RAD_B_UNC;
		go(1'b1, RAD_M_BR8, 16'hA080, RAD_SZ_B);
		chk({bt, bds}, 2'b11);
		chk(btg, 32'h00000F00);
		pc = 32'h00002000;
		go(1'b1, RAD_M_BR12, 16'hA800, RAD_SZ_B);
		chk(btg, 32'h00001000);
		rn = 32'hFFFFFFF0;
		go(1'b1, RAD_M_BRREG, 16'h0323, RAD_SZ_B);
		chk(btg, 32'h00001FF0);
		bk = RAD_B_NONE;
	endtask : t_branch
	task automatic t_imm();
		rad_imm_e kinds [3] = '{RAD_I_ZX, RAD_I_SX, RAD_I_TRAP};
		logic [31:0] exp [3] = '{32'h00000080, 32'hFFFFFF80, 32'h00000200};
		for (int i = 0; i < 3; i++) begin
			ik = kinds[i];
			go(1'b1, RAD_M_NONE, 16'hC880, RAD_SZ_B);
			chk(imm, exp[i]);
		end
		ik = RAD_I_NONE;
	endtask : t_imm
	task automatic t_load();
		logic [31:0] raw [4] = '{32'h12345680, 32'h12348001, 32'h80000001,
			32'hAB00007F};
		logic [31:0] exp [4] = '{32'hFFFFFF80, 32'hFFFF8001, 32'h80000001,
			32'h0000007F};
		logic [1:0] s [4] = '{RAD_SZ_B, RAD_SZ_W, RAD_SZ_L, RAD_SZ_B};
		for (int i = 0; i < 4; i++) begin
			lreq = 1'b1;
			lsz = s[i];
			ldat = raw[i];
			@(posedge clk);
			#1;
			chk({31'h0, lov}, 32'h1);
			chk(lext, exp[i]);
		end
		lreq = 1'b0;
		@(posedge clk);
		#1;
		chk({31'h0, lov}, 32'h0);
	endtask : t_load
	task automatic t_misc();
		logic [31:0] a [4] = '{32'h1001, 32'h1002, 32'h1001, 32'h1004};
		logic [1:0] s [4] = '{RAD_SZ_W, RAD_SZ_L, RAD_SZ_B, RAD_SZ_L};
		logic [3:0] e = 4'b0011;
		for (int i = 0; i < 4; i++) begin
			rn = a[i];
			go(1'b1, RAD_M_IND, 16'h6120, s[i]);
			chk(aerr, e[i]);
		end
		mulacc = 1'b1;
		go(1'b1, RAD_M_POST, 16'h4C3F, RAD_SZ_W);
		chk(s2, 1'b1);
		mulacc = 1'b0;
		lmem = 1'b1;
		go(1'b1, RAD_M_IDX, 16'hCD0F, RAD_SZ_B);
		chk({30'h0, rmw, s2}, 32'h2);
		// a branch mode is no memory operand, so no read-modify-write
		go(1'b1, RAD_M_BR8, 16'hCD0F, RAD_SZ_B);
		chk({31'h0, rmw}, 32'h0);
		lmem = 1'b0;
		go(1'b0, RAD_M_POST, 16'h6A36, RAD_SZ_L);
		chk({ov, wbe}, 2'b00);
	endtask : t_misc
	// **********************************************************
	// clock, watchdog and main sequence
	// **********************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		{iv, mulacc, lmem, flag, lreq} = '0;
		iw = 16'h0000;
		mode = RAD_M_NONE;
		ik = RAD_I_NONE;
		bk = RAD_B_NONE;
		{sz, lsz, pc, rn, rm, r0, gbp, ldat} = '0;
		r0 = 32'h00000010;
		rst = 1'b1;
		// two full edges in reset, released just after the second
		repeat (2) @(posedge clk);
		#1;
		chk({29'h0, ov, wbe, bt}, 32'h0);
		chk(ea, 32'h0);
		rst = 1'b0;
		t_ptr();
		t_disp();
		t_branch();
		t_imm();
		t_load();
		t_misc();
		report_and_stop();
	end
endmodule : tb
